// File: logic/hoos_pkg.sv
// Package with register map, field layout and timing constants of the home offset block.
`default_nettype none
package hoos_pkg;
	localparam int POS_W = 32;
	localparam logic [11:0] ADDR_OFFSET = 12'h000;
	localparam logic [11:0] ADDR_CTRL = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_MAX_POSITION_LIMIT = 12'h00C;
	localparam logic [11:0] ADDR_SAVED = 12'h010;
	localparam logic [11:0] ADDR_CMDPOS = 12'h014;
	localparam logic [11:0] ADDR_MOTION = 12'h018;
	localparam int CTRL_SAVE_BIT = 0;
	localparam int CTRL_SEEK_NEG_BIT = 1;
	localparam int CTRL_SEEK_POS_BIT = 2;
	localparam int CTRL_OUT_EN_BIT = 3;
	localparam int CTRL_LOAD_BIT = 4;
	localparam logic [31:0] OFFSET_RESET = 32'h00000000;
	localparam logic [31:0] MAX_POSITION_LIMIT_RESET = 32'h7FFFFFFF;
	localparam logic [31:0] MOTION_RESET = 32'h0A0A0A0A;
	localparam int STEP_NS = 1000;
	localparam int CLK_NS = 25;
	localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
	typedef struct packed {
		logic [7:0] start_velocity;
		logic [7:0] running_velocity;
		logic [7:0] accel_time;
		logic [7:0] decel_time;
	} hoos_motion_type;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SEEK, ST_OFFSET, ST_ORIGIN, ST_DONE
	} hoos_state_type;
endpackage
`default_nettype wire

// File: logic/hoos_mover.sv
// Trapezoidal step mover that walks a signed distance with a rate profile.
`timescale 1ns/1ps
`default_nettype none
module hoos_mover (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic signed [31:0] distance,
	input wire hoos_pkg::hoos_motion_type motion,
	output logic busy,
	output logic step,
	output logic dir
);
	logic [31:0] remain_ff, nxt_remain;
	logic [15:0] tick_ff, nxt_tick;
	logic [15:0] period_ff, nxt_period;
	logic busy_ff, nxt_busy, step_ff, nxt_step, dir_ff, nxt_dir;

	// Period shrinks from start to running rate while accelerating.
	always_comb begin
		nxt_remain = remain_ff;
		nxt_tick = tick_ff;
		nxt_period = period_ff;
		nxt_busy = busy_ff;
		nxt_step = 1'b0;
		nxt_dir = dir_ff;
		if (start && !busy_ff) begin
			nxt_dir = distance[31];
			nxt_remain = distance[31] ? 32'(-distance) : distance;
			nxt_busy = (distance != 32'h00000000);
			nxt_period = {motion.start_velocity, motion.accel_time};
			nxt_tick = 16'h0000;
		end else if (busy_ff) begin
			if (tick_ff >= period_ff) begin
				nxt_tick = 16'h0000;
				nxt_step = 1'b1;
				nxt_remain = remain_ff - 32'h00000001;
				if (remain_ff == 32'h00000001) begin
					nxt_busy = 1'b0;
				end
				if (remain_ff <= 32'(motion.decel_time)) begin
					nxt_period = period_ff + 16'h0001;
				end else if (period_ff > {8'h00, motion.running_velocity}) begin
					nxt_period = period_ff - 16'h0001;
				end
			end else begin
				nxt_tick = tick_ff + 16'(hoos_pkg::STEP_CYC / hoos_pkg::STEP_CYC);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remain_ff <= 32'h00000000;
			tick_ff <= 16'h0000;
			period_ff <= 16'h0000;
			busy_ff <= 1'b0;
			step_ff <= 1'b0;
			dir_ff <= 1'b0;
		end else begin
			remain_ff <= nxt_remain;
			tick_ff <= nxt_tick;
			period_ff <= nxt_period;
			busy_ff <= nxt_busy;
			step_ff <= nxt_step;
			dir_ff <= nxt_dir;
		end
	end

	assign busy = busy_ff;
	assign step = step_ff;
	assign dir = dir_ff;
endmodule
`default_nettype wire

// File: logic/hoos_top.sv
// Home offset origin set block with an APB register slave.
// Function
// - Offset readable and writable from every source
// - Writes act now; save command persists them
// - Power up loads default; load bit restores saved value
// - After valid home, move by offset
// - Then load zero into commanded position
// - Then set homing complete flag and output
// - Offset move uses configured motion parameters
// - Default offset zero; origin at home
`timescale 1ns/1ps
`default_nettype none
module hoos_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic home_input_state,
	input wire logic seek_step_done,
	output logic homing_complete_output,
	output logic homing_complete_flag,
	output logic motor_step,
	output logic motor_dir,
	output logic seek_active,
	output logic seek_dir_positive
);
	logic [2:0] home_sync_ff;
	logic [31:0] offset_ff, nxt_offset;
	logic [31:0] saved_ff, nxt_saved;
	logic saved_valid_ff, nxt_saved_valid;
	logic [31:0] max_position_limit_ff, nxt_max_position_limit;
	logic [31:0] motion_ff, nxt_motion;
	logic [31:0] cmdpos_ff, nxt_cmdpos;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pslverr_ff, nxt_pslverr;
	logic out_en_ff, nxt_out_en;
	logic flag_ff, nxt_flag;
	logic hout_ff, nxt_hout;
	logic seekdir_ff, nxt_seekdir;
	logic init_ff;
	logic move_start;
	logic mv_busy, mv_step, mv_dir;
	logic wr_acc, rd_acc, in_range, home_seen;
	logic acc_first, wr_err;
	logic pready_ff, nxt_pready;
	logic seek_ff, nxt_seek;
	hoos_pkg::hoos_state_type st_ff, nxt_st;
	hoos_pkg::hoos_motion_type motion_cfg;

	// Errors and read data are judged on the first access edge so that they
	// stand with pready; a write lands only on the edge that sees pready.
	assign acc_first = psel && penable && !pready_ff;
	assign wr_acc = psel && penable && pwrite && pready_ff;
	assign rd_acc = acc_first && !pwrite;
	assign home_seen = home_sync_ff[1] && !home_sync_ff[2];
	assign motion_cfg = hoos_pkg::hoos_motion_type'(motion_ff);

	// Signed range check against the configured position limit.
	always_comb begin
		in_range = ($signed(pwdata) <= $signed(max_position_limit_ff)) &&
			($signed(pwdata) >= -$signed(max_position_limit_ff));
	end

	// Writes to read-only words are ignored quietly; unmapped words fail.
	always_comb begin
		wr_err = 1'b0;
		case (paddr)
			hoos_pkg::ADDR_OFFSET: wr_err = !in_range;
			hoos_pkg::ADDR_CTRL, hoos_pkg::ADDR_STATUS, hoos_pkg::ADDR_MAX_POSITION_LIMIT,
			hoos_pkg::ADDR_SAVED, hoos_pkg::ADDR_CMDPOS,
			hoos_pkg::ADDR_MOTION: wr_err = 1'b0;
			default: wr_err = 1'b1;
		endcase
	end

	// Register file and save store; the save register stands in for NVM.
	always_comb begin
		nxt_offset = offset_ff;
		nxt_saved = saved_ff;
		nxt_saved_valid = saved_valid_ff;
		nxt_max_position_limit = max_position_limit_ff;
		nxt_motion = motion_ff;
		nxt_out_en = out_en_ff;
		nxt_pslverr = 1'b0;
		nxt_prdata = 32'h00000000;
		nxt_pready = psel && penable && !pready_ff;
		if (!init_ff) begin
			nxt_offset = saved_valid_ff ? saved_ff : hoos_pkg::OFFSET_RESET;
		end else if (wr_acc) begin
			case (paddr)
				hoos_pkg::ADDR_OFFSET: begin
					if (in_range) begin
						nxt_offset = pwdata;
					end
				end
				hoos_pkg::ADDR_CTRL: begin
					nxt_out_en = pwdata[hoos_pkg::CTRL_OUT_EN_BIT];
					if (pwdata[hoos_pkg::CTRL_SAVE_BIT]) begin
						nxt_saved = offset_ff;
						nxt_saved_valid = 1'b1;
					end
					if (pwdata[hoos_pkg::CTRL_LOAD_BIT]) begin
						nxt_offset = saved_valid_ff ? saved_ff :
							hoos_pkg::OFFSET_RESET;
					end
				end
				hoos_pkg::ADDR_MAX_POSITION_LIMIT: nxt_max_position_limit = {1'b0, pwdata[30:0]};
				hoos_pkg::ADDR_MOTION: nxt_motion = pwdata;
				// Read-only and unmapped words take no write.
				default: begin
				end
			endcase
		end else if (rd_acc) begin
			case (paddr)
				hoos_pkg::ADDR_OFFSET: nxt_prdata = offset_ff;
				hoos_pkg::ADDR_CTRL: nxt_prdata = {28'h0000000, out_en_ff,
					3'b000};
				hoos_pkg::ADDR_STATUS: nxt_prdata = {26'h0000000, saved_valid_ff,
					mv_busy, seekdir_ff, seek_ff,
					hout_ff, flag_ff};
				hoos_pkg::ADDR_MAX_POSITION_LIMIT: nxt_prdata = max_position_limit_ff;
				hoos_pkg::ADDR_SAVED: nxt_prdata = saved_ff;
				hoos_pkg::ADDR_CMDPOS: nxt_prdata = cmdpos_ff;
				hoos_pkg::ADDR_MOTION: nxt_prdata = motion_ff;
				default: nxt_pslverr = 1'b1;
			endcase
		end else if (acc_first) begin
			nxt_pslverr = wr_err;
		end
	end

	// Homing sequence: seek, offset move, origin set, complete.
	always_comb begin
		nxt_st = st_ff;
		nxt_flag = flag_ff;
		nxt_cmdpos = cmdpos_ff;
		nxt_seekdir = seekdir_ff;
		move_start = 1'b0;
		if (mv_step) begin
			nxt_cmdpos = mv_dir ? cmdpos_ff - 32'h00000001 :
				cmdpos_ff + 32'h00000001;
		end
		case (st_ff)
			hoos_pkg::ST_IDLE: begin
				if (init_ff && wr_acc && paddr == hoos_pkg::ADDR_CTRL &&
					(pwdata[hoos_pkg::CTRL_SEEK_NEG_BIT] ||
					pwdata[hoos_pkg::CTRL_SEEK_POS_BIT])) begin
					nxt_seekdir = pwdata[hoos_pkg::CTRL_SEEK_POS_BIT];
					nxt_flag = 1'b0;
					nxt_st = hoos_pkg::ST_SEEK;
				end
			end
			hoos_pkg::ST_SEEK: begin
				if (home_seen || seek_step_done) begin
					nxt_st = hoos_pkg::ST_OFFSET;
				end
			end
			hoos_pkg::ST_OFFSET: begin
				move_start = 1'b1;
				nxt_st = hoos_pkg::ST_ORIGIN;
			end
			hoos_pkg::ST_ORIGIN: begin
				// A zero offset skips the move so the origin lands on home.
				if (!mv_busy && !move_start) begin
					nxt_cmdpos = 32'h00000000;
					nxt_st = hoos_pkg::ST_DONE;
				end
			end
			hoos_pkg::ST_DONE: begin
				nxt_flag = 1'b1;
				nxt_st = hoos_pkg::ST_IDLE;
			end
			default: nxt_st = hoos_pkg::ST_IDLE;
		endcase
		nxt_hout = nxt_flag && out_en_ff;
		nxt_seek = (nxt_st == hoos_pkg::ST_SEEK);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			home_sync_ff <= 3'b000;
			offset_ff <= hoos_pkg::OFFSET_RESET;
			saved_ff <= hoos_pkg::OFFSET_RESET;
			saved_valid_ff <= 1'b0;
			max_position_limit_ff <= hoos_pkg::MAX_POSITION_LIMIT_RESET;
			motion_ff <= hoos_pkg::MOTION_RESET;
			cmdpos_ff <= 32'h00000000;
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
			out_en_ff <= 1'b0;
			flag_ff <= 1'b0;
			hout_ff <= 1'b0;
			seekdir_ff <= 1'b0;
			init_ff <= 1'b0;
			pready_ff <= 1'b0;
			seek_ff <= 1'b0;
			st_ff <= hoos_pkg::ST_IDLE;
		end else begin
			home_sync_ff <= {home_sync_ff[1:0], home_input_state};
			offset_ff <= nxt_offset;
			saved_ff <= nxt_saved;
			saved_valid_ff <= nxt_saved_valid;
			max_position_limit_ff <= nxt_max_position_limit;
			motion_ff <= nxt_motion;
			cmdpos_ff <= nxt_cmdpos;
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
			out_en_ff <= nxt_out_en;
			flag_ff <= nxt_flag;
			hout_ff <= nxt_hout;
			seekdir_ff <= nxt_seekdir;
			init_ff <= 1'b1;
			pready_ff <= nxt_pready;
			seek_ff <= nxt_seek;
			st_ff <= nxt_st;
		end
	end

	hoos_mover u_mover (
		.pclk(pclk),
		.presetn(presetn),
		.start(move_start),
		.distance(offset_ff),
		.motion(motion_cfg),
		.busy(mv_busy),
		.step(mv_step),
		.dir(mv_dir)
	);

	// Data and error are registered, so the answer needs one wait state.
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign homing_complete_output = hout_ff;
	assign homing_complete_flag = flag_ff;
	assign motor_step = mv_step;
	assign motor_dir = mv_dir;
	assign seek_active = seek_ff;
	assign seek_dir_positive = seekdir_ff;
endmodule
`default_nettype wire

// File: test/hoos_props.sv
// Port checker of the home offset block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module hoos_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic homing_complete_output,
	input wire logic homing_complete_flag,
	input wire logic motor_step,
	input wire logic seek_active
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_homed;
		$rose(homing_complete_flag);
	endsequence
	AST_ANSWER_BOUND: assert property (s_access |-> ##[0:2] pready)
		else $error("access phase not answered in time");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
		else $error("ready without an access phase");
	AST_ERR_AT_ANSWER: assert property ($rose(pslverr) |-> pready)
		else $error("error raised outside an answer");
	AST_OUT_NEEDS_FLAG: assert property (homing_complete_output
		|-> homing_complete_flag || $past(homing_complete_flag))
		else $error("complete output active without the flag");
	AST_FLAG_AFTER_MOVE: assert property (s_homed |-> !seek_active
		&& !motor_step)
		else $error("flag set while still moving");
	AST_FLAG_FALL: assert property ($fell(homing_complete_flag)
		|-> seek_active || $past(seek_active))
		else $error("flag cleared without a new seek");
	AST_SEEK_CLEARS: assert property ($rose(seek_active)
		|-> ##[0:2] !homing_complete_flag)
		else $error("flag kept through a new seek");
	AST_STEP_PULSE: assert property (motor_step |=> !motor_step)
		else $error("step pulse wider than one cycle");
	AST_HOMED_QUIET: assert property (homing_complete_flag && !seek_active
		|-> !motor_step)
		else $error("step after origin was set");
endmodule
bind hoos_top hoos_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.homing_complete_output(homing_complete_output),
	.homing_complete_flag(homing_complete_flag), .motor_step(motor_step),
	.seek_active(seek_active));
`default_nettype wire

// File: test/hoos_drive_model.sv
// Behavioural motor driver and home sensor at the far side of the block.
`timescale 1ns/1ps
`default_nettype none
module hoos_drive_model #(
	parameter int HOME_DLY = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic seek_active,
	input wire logic motor_step,
	input wire logic motor_dir,
	output logic home_input_state,
	output logic seek_step_done,
	output logic signed [31:0] position
);
	int cnt;
	assign seek_step_done = 1'b0;
	// The sensor stays lit until the seek ends, so one rising edge is seen.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			home_input_state <= 1'b0;
			position <= 32'sh0;
		end else begin
			cnt <= seek_active ? cnt + 1 : 0;
			home_input_state <= seek_active && cnt >= HOME_DLY;
			if (seek_active && cnt == HOME_DLY)
				position <= 32'sh0;
			else if (motor_step)
				position <= motor_dir ? position - 1 : position + 1;
		end
	end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench of the home offset block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, home, sdone, out_q, flag, step, dir, seek, sdir;
	logic signed [31:0] pos;
	logic signed [31:0] off;
	logic [33:0] notes[$];
	logic [33:0] n;
	int num_errors = 0;
	int total_checks = 0;
	int seed = 31;
	always #12.5 pclk = ~pclk;
	hoos_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.home_input_state(home), .seek_step_done(sdone),
		.homing_complete_output(out_q), .homing_complete_flag(flag),
		.motor_step(step), .motor_dir(dir), .seek_active(seek),
		.seek_dir_positive(sdir));
	hoos_drive_model drv (.pclk(pclk), .presetn(presetn),
		.seek_active(seek), .motor_step(step), .motor_dir(dir),
		.home_input_state(home), .seek_step_done(sdone), .position(pos));
	task automatic chk(input string what, input logic [31:0] e, g);
		total_checks++;
		if (e !== g) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic close_out;
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [33:0] note);
		int k;
		notes.push_back(note);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50 && pready !== 1'b1; k++)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 50) begin
			num_errors++;
			close_out();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, {2'b10, x});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input e);
		apb(1'b1, a, d, {1'b0, e, 32'h0});
	endtask
	// Seek, then wait for the flag; the model counts steps after home.
	task automatic home_run(input logic [31:0] ctl, input logic [31:0] x);
		int k;
		wr(hoos_pkg::ADDR_CTRL, ctl, 1'b0);
		for (k = 0; k < 20 && seek !== 1'b1; k++)
			@(posedge pclk);
		for (k = 0; k < 40000 && flag !== 1'b1; k++)
			@(posedge pclk);
		if (k == 40000) begin
			num_errors++;
			close_out();
		end
		chk("steps", x, pos);
		rd(hoos_pkg::ADDR_CMDPOS, 32'h0);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			chk("pslverr", {31'h0, n[32]}, {31'h0, pslverr});
			if (n[33])
				chk("prdata", n[31:0], prdata);
		end
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(hoos_pkg::ADDR_OFFSET, hoos_pkg::OFFSET_RESET);
		rd(hoos_pkg::ADDR_MAX_POSITION_LIMIT, hoos_pkg::MAX_POSITION_LIMIT_RESET);
		rd(hoos_pkg::ADDR_MOTION, hoos_pkg::MOTION_RESET);
		wr(12'h01C, 32'h0, 1'b1);
		off = $random(seed) % 16;
		wr(hoos_pkg::ADDR_OFFSET, off, 1'b0);
		rd(hoos_pkg::ADDR_OFFSET, off);
		wr(hoos_pkg::ADDR_MAX_POSITION_LIMIT, 32'h64, 1'b0);
		wr(hoos_pkg::ADDR_OFFSET, 32'h65, 1'b1);
		wr(hoos_pkg::ADDR_OFFSET, 32'hFFFFFF9B, 1'b1);
		rd(hoos_pkg::ADDR_OFFSET, off);
		wr(hoos_pkg::ADDR_MOTION, 32'h01080402, 1'b0);
		home_run(32'h0C, off);
		chk("output", 32'h1, {31'h0, out_q});
		chk("seekdir", 32'h1, {31'h0, sdir});
		rd(hoos_pkg::ADDR_STATUS, 32'h0000000B);
		rd(hoos_pkg::ADDR_CTRL, 32'h00000008);
		wr(hoos_pkg::ADDR_CTRL, 32'h01, 1'b0);
		rd(hoos_pkg::ADDR_SAVED, off);
		wr(hoos_pkg::ADDR_OFFSET, 32'h0, 1'b0);
		home_run(32'h02, 32'h0);
		chk("output", 32'h0, {31'h0, out_q});
		chk("seekdir", 32'h0, {31'h0, sdir});
		wr(hoos_pkg::ADDR_CTRL, 32'h10, 1'b0);
		rd(hoos_pkg::ADDR_OFFSET, off);
		close_out();
	end
endmodule
`default_nettype wire
